// >>> inc/dmb_params.svh
`ifndef DMB_PARAMS_SVH
`define DMB_PARAMS_SVH

// register byte offsets on the AHB-Lite slave
`define DMB_REG_MODE     32'h0000_0000
`define DMB_REG_STATUS   32'h0000_0004
`define DMB_REG_CTRL     32'h0000_0008
`define DMB_ADDR_DEC_W   4

// reset values
`define DMB_CTRL_RST     2'h3
`define DMB_MODE_RST     13'h0022

// ctrl fields
`define DMB_CTRL_EN_BIT  0
`define DMB_CTRL_WIDE_BIT 1

// address bus and mode word layout
`define DMB_ADDR_W       13
`define DMB_BL_LSB       0
`define DMB_BT_BIT       3
`define DMB_LAT_LSB      4
`define DMB_DLL_BIT      8
`define DMB_OPM_LSB      7
`define DMB_AP_BIT       10
`define DMB_SELFCLR_MASK 13'h0100

// burst length codes
`define DMB_BL_CODE2     3'h1
`define DMB_BL_CODE4     3'h2
`define DMB_BL_CODE8     3'h3

// read latency codes and their delay in link clock edges
`define DMB_LAT_CODE20   3'h2
`define DMB_LAT_CODE25   3'h6
`define DMB_LAT_EDGES20  3'h4
`define DMB_LAT_EDGES25  3'h5

// status fields
`define DMB_ST_OPEN_LSB  0
`define DMB_ST_RD_BIT    4
`define DMB_ST_WR_BIT    5
`define DMB_ST_RSV_BIT   6
`define DMB_ST_DLL_LSB   8

`endif

// >>> inc/dmb_pkg.sv
package dmb_pkg;

  // burst engine states
  typedef enum logic [3:0] {
    DMB_ST_IDLE    = 4'b0001,
    DMB_ST_RDWAIT  = 4'b0010,
    DMB_ST_RDBURST = 4'b0100,
    DMB_ST_WRBURST = 4'b1000
  } dmb_state_e;

  // command code as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    DMB_CMD_MRS = 3'b000,
    DMB_CMD_REF = 3'b001,
    DMB_CMD_PRE = 3'b010,
    DMB_CMD_ACT = 3'b011,
    DMB_CMD_WR  = 3'b100,
    DMB_CMD_RD  = 3'b101,
    DMB_CMD_BST = 3'b110,
    DMB_CMD_NOP = 3'b111
  } dmb_cmd_e;

endpackage

// >>> inc/dmb_mode_if.sv
`include "dmb_params.svh"

// decoded mode settings shared by the burst logic
interface dmb_mode_if;
  logic [`DMB_ADDR_W-1:0] modeWord;
  logic [3:0]             burstBeats;
  logic [2:0]             burstMask;
  logic                   interleave;
  logic [2:0]             latencyEdges;
  logic                   reservedCode;
  logic                   dllResetPulse;

  modport src (
    output modeWord, burstBeats, burstMask, interleave,
    output latencyEdges, reservedCode, dllResetPulse
  );
  modport dst (
    input modeWord, burstBeats, burstMask, interleave,
    input latencyEdges, reservedCode, dllResetPulse
  );
endinterface

// >>> hw/dmb_mode_reg.sv
`include "dmb_params.svh"

module dmb_mode_reg (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   ce,
  // load request from the command decoder
  input  wire logic                   loadStrobe,
  input  wire logic [`DMB_ADDR_W-1:0] opCode,
  // decoded settings
  dmb_mode_if.src                     mode
);

  logic [`DMB_ADDR_W-1:0] modeReg;
  logic                   dllPulseReg;

  // op-code store; the dll bit never stays set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      modeReg <= `DMB_MODE_RST;
    end else if (ce && loadStrobe) begin
      modeReg <= opCode & ~`DMB_SELFCLR_MASK;
    end
  end

  // dll reset only with the other mode bits clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dllPulseReg <= 1'b0;
    end else if (ce) begin
      dllPulseReg <= loadStrobe && opCode[`DMB_DLL_BIT] &&
                     !opCode[`DMB_OPM_LSB] &&
                     (opCode[`DMB_ADDR_W-1:`DMB_DLL_BIT+1] == '0);
    end
  end

  // field decode; reserved codes fall back to the smallest setting
  always_comb begin
    mode.modeWord      = modeReg;
    mode.interleave    = modeReg[`DMB_BT_BIT];
    mode.dllResetPulse = dllPulseReg;
    mode.reservedCode  = (modeReg[`DMB_ADDR_W-1:`DMB_OPM_LSB] != '0);
    case (modeReg[`DMB_BL_LSB+:3])
      `DMB_BL_CODE2: begin
        mode.burstBeats = 4'h2;
        mode.burstMask  = 3'h1;
      end
      `DMB_BL_CODE4: begin
        mode.burstBeats = 4'h4;
        mode.burstMask  = 3'h3;
      end
      `DMB_BL_CODE8: begin
        mode.burstBeats = 4'h8;
        mode.burstMask  = 3'h7;
      end
      default: begin
        mode.burstBeats   = 4'h2;
        mode.burstMask    = 3'h1;
        mode.reservedCode = 1'b1;
      end
    endcase
    case (modeReg[`DMB_LAT_LSB+:3])
      `DMB_LAT_CODE20: mode.latencyEdges = `DMB_LAT_EDGES20;
      `DMB_LAT_CODE25: mode.latencyEdges = `DMB_LAT_EDGES25;
      default: begin
        mode.latencyEdges = `DMB_LAT_EDGES20;
        mode.reservedCode = 1'b1;
      end
    endcase
  end

endmodule // dmb_mode_reg

// >>> hw/dmb_burst_seq.sv
module dmb_burst_seq #(
  parameter int COLW = 10
) (
  // burst origin and the pair of beats wanted
  input  wire logic [COLW-1:0] startCol,
  input  wire logic [1:0]      pairIdx,
  // decoded settings
  dmb_mode_if.dst              mode,
  // columns of the even and odd beat
  output logic      [COLW-1:0] colEven,
  output logic      [COLW-1:0] colOdd
);

  // wraps inside the aligned block; upper bits never change
  function automatic logic [COLW-1:0] colOf(
    input logic [COLW-1:0] start,
    input logic [2:0]      k,
    input logic [2:0]      mask,
    input logic            il
  );
    logic [2:0] low;
    low = il ? ((start[2:0] ^ k) & mask)
             : ((start[2:0] + k) & mask);
    colOf = {start[COLW-1:3], (start[2:0] & ~mask) | low};
  endfunction

  // two columns a clock, one array word of twice the pin width
  assign colEven = colOf(startCol, {pairIdx, 1'b0}, mode.burstMask,
                         mode.interleave);
  assign colOdd  = colOf(startCol, {pairIdx, 1'b1}, mode.burstMask,
                         mode.interleave);

endmodule // dmb_burst_seq

// >>> hw/dmb_ddr_top.sv
`include "dmb_params.svh"

// Behaviour
// - commands and address are taken only at the rising link clock edge
// - write data latched on both strobe edges; reads launched on both
// - strobe driven by the device only in reads, edge aligned with data
// - one double-width array word per clock, two pin words per clock
// - activate takes bank bits and row; row is 12 or 13 bits wide
// - read and write take bank and first column from that command
// - burst lengths of 2, 4 and 8 for both orderings
// - auto precharge closes the row at the end of the burst
// - mode set with bank bits zero loads the mode word; it persists
// - the dll reset bit clears itself; other bits persist
// - a mode rewrite leaves the stored array contents alone
// - mode word: length, order bit, latency, operating mode fields
// - length codes 1, 2, 3 mean 2, 4, 8; the rest reserved
// - the order select bit picks sequential or interleaved bursts
// - burst stays in an aligned block and wraps at its edge
// - one programmed length serves both reads and writes
// - read latency is two or two and a half clocks
// - first read data at command edge plus latency
// - normal operation needs every operating mode bit zero
// - dll reset needs the dll bit set, the other mode bits zero
// - interleaved xors the start, sequential increments with wrap

module dmb_ddr_top #(
  parameter int DQW     = 8,
  parameter int COLW    = 10,
  parameter int MEMCOLW = 4
) (
  // system clock, reset, freeze
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   ce,
  // link clock and command pins
  input  wire logic                   ckPin,
  input  wire logic                   ckNPin,
  input  wire logic                   ckePin,
  input  wire logic                   csNPin,
  input  wire logic                   rasNPin,
  input  wire logic                   casNPin,
  input  wire logic                   weNPin,
  input  wire logic [1:0]             baPin,
  input  wire logic [`DMB_ADDR_W-1:0] addrPin,
  // data and strobe pins
  input  wire logic [DQW-1:0]         dqIn,
  output logic      [DQW-1:0]         dqOut,
  output logic                        dqOeN,
  input  wire logic                   dqsIn,
  output logic                        dqsOut,
  output logic                        dqsOeN,
  input  wire logic                   dmPin,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic      [31:0]            hrdata,
  output logic                        hresp
);

  localparam int PINW  = 11 + `DMB_ADDR_W + DQW;
  localparam int DEPTH = 4 << MEMCOLW;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and link edge detection

  logic [PINW-1:0]         sync1Reg;
  logic [PINW-1:0]         sync2Reg;
  logic                    ckPrevReg;
  logic                    dqsPrevReg;
  logic                    sCk;
  logic                    sCkN;
  logic                    sCke;
  logic                    sCsN;
  logic [2:0]              sCmd;
  logic [1:0]              sBa;
  logic [`DMB_ADDR_W-1:0]  sAddr;
  logic                    sDqs;
  logic                    sDm;
  logic [DQW-1:0]          sDq;
  logic                    ckRise;
  logic                    linkEdge;
  logic                    dqsEdge;

  // every pin shares one two-stage chain so fields stay aligned
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1Reg <= '0;
      sync2Reg <= '0;
    end else if (ce) begin
      sync1Reg <= {ckPin, ckNPin, ckePin, csNPin, rasNPin, casNPin,
                   weNPin, baPin, addrPin, dqsIn, dmPin, dqIn};
      sync2Reg <= sync1Reg;
    end
  end

  assign {sCk, sCkN, sCke, sCsN, sCmd, sBa, sAddr, sDqs, sDm, sDq} =
    sync2Reg;

  // previous levels for edge finding
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ckPrevReg  <= 1'b0;
      dqsPrevReg <= 1'b0;
    end else if (ce) begin
      ckPrevReg  <= sCk;
      dqsPrevReg <= sDqs;
    end
  end

  assign ckRise   = sCk && !sCkN && !ckPrevReg;
  assign linkEdge = sCk != ckPrevReg;
  assign dqsEdge  = sDqs != dqsPrevReg;

  ////////////////////////////////////////////////////////////////////////
  // command decode

  logic [1:0]              ctrlReg;
  dmb_pkg::dmb_cmd_e       cmd;
  logic                    cmdTaken;
  logic                    mrsLoad;
  logic                    accessCmd;

  // deselect, cke low or a disabled decoder mask the command
  assign cmd       = dmb_pkg::dmb_cmd_e'(sCmd);
  assign cmdTaken  = ckRise && sCke && !sCsN &&
                     ctrlReg[`DMB_CTRL_EN_BIT];
  assign mrsLoad   = cmdTaken && (cmd == dmb_pkg::DMB_CMD_MRS) &&
                     (sBa == 2'h0);
  assign accessCmd = cmdTaken && ((cmd == dmb_pkg::DMB_CMD_RD) ||
                                  (cmd == dmb_pkg::DMB_CMD_WR));

  dmb_mode_if modeBus ();

  dmb_mode_reg u_mode (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .ce         (ce),
    .loadStrobe (mrsLoad),
    .opCode     (sAddr),
    .mode       (modeBus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // bank rows

  logic [3:0]              rowOpenReg;
  logic [`DMB_ADDR_W-1:0]  rowReg [0:3];
  logic                    burstEnd;
  logic [1:0]              bankReg;
  logic                    autoPreReg;

  // open rows; the narrow part ignores the top address bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rowOpenReg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        rowReg[b] <= '0;
      end
    end else if (ce) begin
      if (burstEnd && autoPreReg) begin
        rowOpenReg[bankReg] <= 1'b0;
      end
      if (cmdTaken && cmd == dmb_pkg::DMB_CMD_ACT) begin
        rowOpenReg[sBa] <= 1'b1;
        rowReg[sBa]     <= ctrlReg[`DMB_CTRL_WIDE_BIT] ? sAddr
          : {1'b0, sAddr[`DMB_ADDR_W-2:0]};
      end else if (cmdTaken && cmd == dmb_pkg::DMB_CMD_PRE) begin
        if (sAddr[`DMB_AP_BIT]) begin
          rowOpenReg <= 4'h0;
        end else begin
          rowOpenReg[sBa] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst engine

  dmb_pkg::dmb_state_e     stateReg;
  logic [COLW-1:0]         startColReg;
  logic [3:0]              beatReg;
  logic [2:0]              waitReg;
  logic [COLW-1:0]         colEven;
  logic [COLW-1:0]         colOdd;
  logic [DQW-1:0]          memArr [0:DEPTH-1];
  logic [DQW-1:0]          lowHalfReg;
  logic                    lowMaskReg;
  logic [DQW-1:0]          highHalfReg;
  logic                    lastBeat;
  logic                    rdEnd;
  logic                    burstDone;
  logic                    beatStep;

  // array index from bank and low column bits
  function automatic logic [MEMCOLW+1:0] memIdx(
    input logic [1:0]      bank,
    input logic [COLW-1:0] col
  );
    memIdx = {bank, col[MEMCOLW-1:0]};
  endfunction

  dmb_burst_seq #(
    .COLW (COLW)
  ) u_seq (
    .startCol (startColReg),
    .pairIdx  (beatReg[2:1]),
    .mode     (modeBus.dst),
    .colEven  (colEven),
    .colOdd   (colOdd)
  );

  // one length for both directions
  assign lastBeat = beatReg + 4'h1 == modeBus.burstBeats;
  // reads need one more edge so the last beat stands a full half clock
  assign rdEnd     = beatReg == modeBus.burstBeats;
  assign burstDone = (stateReg == dmb_pkg::DMB_ST_WRBURST) ? lastBeat
                                                           : rdEnd;
  assign beatStep = (stateReg == dmb_pkg::DMB_ST_WRBURST) ? dqsEdge
                                                          : linkEdge;
  assign burstEnd = beatStep && burstDone &&
                    (stateReg == dmb_pkg::DMB_ST_WRBURST ||
                     stateReg == dmb_pkg::DMB_ST_RDBURST);

  // sequencing; a new access cuts short any running burst
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stateReg    <= dmb_pkg::DMB_ST_IDLE;
      startColReg <= '0;
      bankReg     <= 2'h0;
      autoPreReg  <= 1'b0;
      beatReg     <= 4'h0;
      waitReg     <= 3'h0;
    end else if (ce) begin
      if (accessCmd) begin
        startColReg <= sAddr[COLW-1:0];
        bankReg     <= sBa;
        autoPreReg  <= sAddr[`DMB_AP_BIT];
        beatReg     <= 4'h0;
        waitReg     <= modeBus.latencyEdges - 3'h1;
        stateReg    <= (cmd == dmb_pkg::DMB_CMD_RD)
          ? dmb_pkg::DMB_ST_RDWAIT : dmb_pkg::DMB_ST_WRBURST;
      end else begin
        case (stateReg)
          dmb_pkg::DMB_ST_IDLE: begin
            beatReg <= 4'h0;
          end
          dmb_pkg::DMB_ST_RDWAIT: begin
            if (linkEdge) begin
              waitReg <= waitReg - 3'h1;
              if (waitReg == 3'h1) begin
                stateReg <= dmb_pkg::DMB_ST_RDBURST;
              end
            end
          end
          dmb_pkg::DMB_ST_RDBURST, dmb_pkg::DMB_ST_WRBURST: begin
            if (beatStep) begin
              beatReg <= beatReg + 4'h1;
              if (burstDone) begin
                stateReg <= dmb_pkg::DMB_ST_IDLE;
              end
            end
          end
          default: begin
            stateReg <= dmb_pkg::DMB_ST_IDLE;
          end
        endcase
      end
    end
  end

  // write path: even beat held, pair stored as one wide word
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lowHalfReg <= '0;
      lowMaskReg <= 1'b0;
    end else if (ce && beatStep &&
                 stateReg == dmb_pkg::DMB_ST_WRBURST) begin
      if (!beatReg[0]) begin
        lowHalfReg <= sDq;
        lowMaskReg <= sDm;
      end else begin
        if (!lowMaskReg) begin
          memArr[memIdx(bankReg, colEven)] <= lowHalfReg;
        end
        if (!sDm) begin
          memArr[memIdx(bankReg, colOdd)] <= sDq;
        end
      end
    end
  end

  // read path: fetch both halves on the even beat, send the odd later
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dqOut       <= '0;
      dqOeN       <= 1'b1;
      dqsOut      <= 1'b0;
      dqsOeN      <= 1'b1;
      highHalfReg <= '0;
    end else if (ce) begin
      if (stateReg == dmb_pkg::DMB_ST_RDBURST && linkEdge &&
          !accessCmd) begin
        dqOeN  <= rdEnd;
        dqsOeN <= rdEnd;
        dqsOut <= !rdEnd && !beatReg[0];
        if (!beatReg[0]) begin
          dqOut       <= memArr[memIdx(bankReg, colEven)];
          highHalfReg <= memArr[memIdx(bankReg, colOdd)];
        end else begin
          dqOut <= highHalfReg;
        end
      end else if (stateReg != dmb_pkg::DMB_ST_RDBURST || accessCmd) begin
        dqOeN  <= 1'b1;
        dqsOeN <= 1'b1;
        dqsOut <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave

  logic                    wrPendReg;
  logic [`DMB_ADDR_DEC_W-1:0] wrAddrReg;
  logic [31:0]             hrdataReg;
  logic [7:0]              dllCountReg;
  logic [31:0]             statusWord;
  logic                    addrPhase;

  // counts dll reset requests; wraps silently
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dllCountReg <= 8'h00;
    end else if (ce && modeBus.dllResetPulse) begin
      dllCountReg <= dllCountReg + 8'h01;
    end
  end

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`DMB_ST_OPEN_LSB+:4] = rowOpenReg;
    statusWord[`DMB_ST_RD_BIT] = stateReg == dmb_pkg::DMB_ST_RDWAIT ||
                                 stateReg == dmb_pkg::DMB_ST_RDBURST;
    statusWord[`DMB_ST_WR_BIT] = stateReg == dmb_pkg::DMB_ST_WRBURST;
    statusWord[`DMB_ST_RSV_BIT] = modeBus.reservedCode;
    statusWord[`DMB_ST_DLL_LSB+:8] = dllCountReg;
  end

  // zero wait states; a frozen block stalls the bus instead
  assign addrPhase = hsel && htrans[1] && hready && ce;
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataReg;

  // address phase: latch write target or prepare read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPendReg <= 1'b0;
      wrAddrReg <= '0;
      hrdataReg <= 32'h0000_0000;
    end else if (ce) begin
      wrPendReg <= addrPhase && hwrite;
      wrAddrReg <= haddr[`DMB_ADDR_DEC_W-1:0];
      if (addrPhase && !hwrite) begin
        case (haddr[`DMB_ADDR_DEC_W-1:0])
          `DMB_REG_MODE:   hrdataReg <= 32'(modeBus.modeWord);
          `DMB_REG_STATUS: hrdataReg <= statusWord;
          `DMB_REG_CTRL:   hrdataReg <= 32'(ctrlReg);
          default:         hrdataReg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // data phase write; only control is writable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrlReg <= `DMB_CTRL_RST;
    end else if (ce && wrPendReg &&
                 wrAddrReg == `DMB_ADDR_DEC_W'(`DMB_REG_CTRL)) begin
      ctrlReg <= hwdata[1:0];
    end
  end

endmodule // dmb_ddr_top

// >>> test/dmb_ddr_sva.sv
module dmb_ddr_sva (
  // clock, reset, freeze
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        ce,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // read path drive
  input wire logic        dqOeN,
  input wire logic        dqsOut,
  input wire logic        dqsOeN
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // read address phase accepted at a given offset
  sequence s_rd_addr(logic [3:0] off);
    hsel && htrans[1] && !hwrite && hready && ce && haddr[3:0] == off;
  endsequence
  // a beat stays put with the drivers on
  sequence s_beat_hold;
    (!dqsOeN && $stable(dqsOut))[*3];
  endsequence

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  ready_ce_a: assert property (hreadyout == ce)
    else $error("hreadyout does not follow ce");
  oe_pair_a: assert property (dqOeN == dqsOeN)
    else $error("data and strobe drive differ");
  reset_idle_a: assert property ($fell(srst) |-> dqOeN && dqsOeN
    && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  first_beat_a: assert property ($fell(dqOeN) |-> dqsOut)
    else $error("first read beat strobe not high");
  beat_hold_a: assert property
    (!dqsOeN && $changed(dqsOut) |=> s_beat_hold)
    else $error("read beat too short");
  burst_span_a: assert property
    ($fell(dqsOeN) |-> ##[9:41] $rose(dqsOeN))
    else $error("read burst length out of range");
  unmapped_zero_a: assert property (s_rd_addr(4'hc) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  mode_width_a: assert property
    (s_rd_addr(4'h0) |=> hrdata[31:13] == 19'h0)
    else $error("mode word wider than 13 bits");
endmodule // dmb_ddr_sva

bind dmb_ddr_top dmb_ddr_sva chk_u (
  .clk_sys(clk_sys), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .dqOeN(dqOeN), .dqsOut(dqsOut), .dqsOeN(dqsOeN)
);

// >>> test/dmb_ctl_model.sv
module dmb_ctl_model (
  // link clock and command pins
  output logic        ckPin,
  output logic        ckNPin,
  output logic        ckePin,
  output logic        csNPin,
  output logic        rasNPin,
  output logic        casNPin,
  output logic        weNPin,
  output logic [1:0]  baPin,
  output logic [12:0] addrPin,
  // write data, mask and strobe
  output logic [7:0]  dqIn,
  output logic        dqsIn,
  output logic        dmPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // free link clock, edges offset from clk_sys
  initial begin
    {ckPin, ckePin, csNPin, rasNPin, casNPin, weNPin} = 6'h1f;
    {baPin, addrPin, dqIn, dqsIn, dmPin} = '0;
    #1;
    forever #40 ckPin = ~ckPin;
  end
  assign ckNPin = ~ckPin;
  // command held over one rising ck edge
  task automatic cmd(input dmb_pkg::dmb_cmd_e c, input logic [1:0] ba,
                     input logic [12:0] a);
    @(negedge ckPin);
    csNPin <= 1'b0;
    {rasNPin, casNPin, weNPin} <= c;
    baPin <= ba;
    addrPin <= a;
    @(negedge ckPin);
    csNPin <= 1'b1;
    {rasNPin, casNPin, weNPin} <= 3'b111;
    addrPin <= ~a;
  endtask
  // strobe edge centred in each data beat, only during writes
  task automatic wrData(input int n, input logic [7:0] d0, msk);
    for (int i = 0; i < n; i++) begin
      dqIn <= d0 + 8'(i);
      dmPin <= msk[i];
      #20;
      dqsIn <= ~dqsIn;
      #20;
    end
    dqIn <= ~dqIn;
    dmPin <= 1'b0;
  endtask
endmodule // dmb_ctl_model

// >>> test/dmb_ddr_top_tb.sv
`include "dmb_params.svh"

`define CHK(act, exp) begin \
  total_checks++; \
  if ((act) !== (exp)) begin \
    n_fail++; \
    $display("Error at %0t: got %h want %h", $time, act, exp); \
  end \
end

module dmb_ddr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        srst, ce, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hready, hreadyout, hresp, dqOeN, dqsOut, dqsOeN;
  wire  [31:0] hrdata;
  wire  [7:0]  dqOut, dqIn;
  wire         ckPin, ckNPin, ckePin, csNPin, rasNPin, casNPin, weNPin;
  wire         dqsIn, dmPin;
  wire  [1:0]  baPin;
  wire  [12:0] addrPin;
  logic [7:0]  mem [16];
  logic [7:0]  rdQ [$];
  logic        prevOe = 1'b1;
  logic        prevDqs = 1'b0;
  int          n_fail = 0, total_checks = 0, cyc = 0, rdT0, latCyc;

  always #4 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  // every bench net carries the port's own name
  dmb_ddr_top dut_u (.*);
  dmb_ctl_model ctl_u (.*);

  ////////////////////////////////////////////////////////////////////
  // read command moment, in clk_sys cycles
  always @(posedge ckPin)
    if (!csNPin && {rasNPin, casNPin, weNPin} == dmb_pkg::DMB_CMD_RD)
      rdT0 = cyc;
  // one beat per strobe change while driven; first beat marks latency
  always @(posedge clk_sys) begin
    prevOe <= dqOeN;
    prevDqs <= dqsOut;
    if (!dqOeN && (prevOe || dqsOut !== prevDqs)) rdQ.push_back(dqOut);
    if (!dqOeN && prevOe) latCyc = cyc - rdT0;
  end
  // hang guard, far above the seven hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single ahb-lite transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [31:0] a, m, e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    `CHK(d & m, e)
  endtask
  task automatic mrs(input logic [12:0] md);
    ctl_u.cmd(dmb_pkg::DMB_CMD_MRS, 2'd0, md);
  endtask
  // column of beat k: xor inside the block, or increment with wrap
  function automatic logic [3:0] ord(input logic [3:0] s, input int k,
                                     input int bl, input logic il);
    logic [3:0] m;
    m = 4'(bl - 1);
    return il ? (s ^ 4'(k)) : ((s & ~m) | ((s + 4'(k)) & m));
  endfunction
  task automatic wrBurst(input logic [12:0] md, input logic [3:0] c,
                         input logic [7:0] d0, msk);
    int bl;
    bl = 1 << md[2:0];
    mrs(md);
    ctl_u.cmd(dmb_pkg::DMB_CMD_WR, 2'd1, {9'h000, c});
    ctl_u.wrData(bl, d0, msk);
    for (int k = 0; k < bl; k++)
      if (!msk[k]) mem[ord(c, k, bl, md[3])] = d0 + 8'(k);
  endtask
  task automatic rdBurst(input logic [12:0] md, input logic [3:0] c,
                         input logic ap);
    int bl;
    int lo;
    bl = 1 << md[2:0];
    lo = (md[6:4] == `DMB_LAT_CODE25) ? 25 : 20;
    mrs(md);
    rdQ.delete();
    ctl_u.cmd(dmb_pkg::DMB_CMD_RD, 2'd1, {2'b00, ap, 6'h00, c});
    for (int i = 0; i < 100 && rdQ.size() < bl; i++) @(posedge clk_sys);
    `CHK(rdQ.size(), bl)
    `CHK((latCyc - lo) inside {[1:5]}, 1'b1)
    for (int k = 0; k < bl && k < rdQ.size(); k++)
      `CHK(rdQ[k], mem[ord(c, k, bl, md[3])])
    repeat (10) @(posedge clk_sys);
    $display("read burst mode %h col %h done", md, c);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d;
    logic [16:0] rsv [4] = '{17'h0_0022, 17'h1_0024, 17'h1_00a2,
                             17'h1_0052};
    {srst, ce, hsel, hwrite, htrans, haddr, hwdata} = {2'b11, 68'h0};
    hsize = 3'b010;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0022);
    rdChk(`DMB_REG_CTRL, 32'hffff_ffff, 32'h0000_0003);
    rdChk(`DMB_REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    rdChk(32'h0000_000c, 32'hffff_ffff, 32'h0000_0000);
    ahb(1'b1, `DMB_REG_MODE, 32'h0000_0fff, d);
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0022);
    $display("register reset test done");
    mrs(13'h0163);
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0063);
    rdChk(`DMB_REG_STATUS, 32'h0000_ff00, 32'h0000_0100);
    ctl_u.cmd(dmb_pkg::DMB_CMD_MRS, 2'd1, 13'h0007);
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0063);
    ahb(1'b1, `DMB_REG_CTRL, 32'h0000_0002, d);
    mrs(13'h0022);
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0063);
    ahb(1'b1, `DMB_REG_CTRL, 32'h0000_0003, d);
    foreach (rsv[i]) begin
      mrs(rsv[i][12:0]);
      rdChk(`DMB_REG_STATUS, 32'h40, {25'h0, rsv[i][16], 6'h0});
    end
    $display("mode set test done");
    ctl_u.cmd(dmb_pkg::DMB_CMD_ACT, 2'd1, 13'h1abc);
    rdChk(`DMB_REG_STATUS, 32'h0000_000f, 32'h0000_0002);
    wrBurst(13'h0023, 4'h0, 8'ha0, 8'h00);
    wrBurst(13'h0022, 4'h4, 8'hb0, 8'h0b);
    rdBurst(13'h0022, 4'h5, 1'b0);
    rdBurst(13'h002a, 4'h5, 1'b0);
    rdBurst(13'h0061, 4'h7, 1'b0);
    rdBurst(13'h002b, 4'h3, 1'b1);
    rdChk(`DMB_REG_STATUS, 32'h0000_000f, 32'h0000_0000);
    $display("burst test done");
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    srst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(`DMB_REG_MODE, 32'hffff_ffff, 32'h0000_0022);
    $display("freeze and reset test done");
    results();
  end
endmodule // dmb_ddr_top_tb
